/* File: bench/prog_model.sv */
// Programmer model: shifts code+payload frames over the programming pins.
// Assumes the device samples and changes its data on the rising prog clock.
`timescale 1ns/1ps

module prog_model (
    input  wire logic mclk,
    input  wire logic prog_data_out,
    input  wire logic prog_data_oe_n,
    output logic      prog_clock_pin,
    output logic      prog_data_in
);
    logic host_d = 1'b0;

    initial prog_clock_pin = 1'b0;

    // Wire level: the device wins while it drives, else the host
    assign prog_data_in = prog_data_oe_n ? host_d : prog_data_out;

    task automatic frame(input logic [3:0] code, input logic [23:0] pl, output logic [23:0] rd);
        logic [27:0] bits;
        bits = {pl, code};
        rd = 24'h0;
        for (int i = 0; i < 28; i++)
        begin
            // Released line toggles so a stale level never passes for data
            host_d <= (code == 4'h1 && i > 3) ? ~host_d : bits[i];
            repeat (10) @(posedge mclk);
            prog_clock_pin <= 1'b1;
            repeat (10) @(posedge mclk);
            if (i > 3) rd[i-4] = prog_data_in;
            prog_clock_pin <= 1'b0;
        end
        repeat (10) @(posedge mclk);
    endtask : frame
endmodule : prog_model

/* File: bench/tb.sv */
// Bench for the serial programming port: programmer model plus memory model.
// Assumes memory answers one cycle after it sees mem_rd.
`timescale 1ns/1ps
`define CHK(a, b) begin checked++; if ((a) !== (b)) begin mismatches++; \
    $display("ERROR %0t got %h exp %h", $time, (a), (b)); end end

module tb;
    import prog_port_pkg::*;
    localparam logic [15:0] APP_ID  = 16'h00c7;  // Arbitrary neutral value
    localparam int          P16_CYC = 50;        // Quiet time before leaving mode
    logic        mclk             = 1'b0;
    logic        rst_n            = 1'b0;
    logic        master_clear_pin = 1'b0;
    logic        prog_clock_pin;
    logic        prog_data_in;
    logic        prog_data_out;
    logic        prog_data_oe_n;
    logic [23:0] mem_addr;
    logic        mem_rd;
    logic [15:0] mem_rdata        = 16'h0000;
    logic [15:0] visibility_out;
    logic [7:0]  table_page;
    int          mismatches       = 0;
    int          checked          = 0;
    int          rd_cnt           = 0;

    always #4 mclk = ~mclk;

    serial_prog_config_readback #(.APP_ID_VALUE(APP_ID)) u_serial_prog_config_readback (
        .mclk(mclk), .rst_n(rst_n), .master_clear_pin(master_clear_pin),
        .prog_clock_pin(prog_clock_pin), .prog_data_in(prog_data_in),
        .prog_data_out(prog_data_out), .prog_data_oe_n(prog_data_oe_n),
        .mem_addr(mem_addr), .mem_rd(mem_rd), .mem_rdata(mem_rdata),
        .visibility_out(visibility_out), .table_page(table_page));

    prog_model u_prog_model (
        .mclk(mclk), .prog_data_out(prog_data_out), .prog_data_oe_n(prog_data_oe_n),
        .prog_clock_pin(prog_clock_pin), .prog_data_in(prog_data_in));

    function automatic logic [15:0] memf(input logic [23:0] a);
        return a[15:0] ^ {a[23:16], 8'h3c};
    endfunction : memf

    // Memory answers the cycle after a read strobe and counts strobes
    always @(posedge mclk)
    begin
        if (mem_rd === 1'b1)
        begin
            mem_rdata <= memf(mem_addr);
            rd_cnt <= rd_cnt + 1;
        end
    end

    task automatic seq(input logic [23:0] q[$]);
        logic [23:0] d;
        foreach (q[i]) u_prog_model.frame(4'h0, q[i], d);
    endtask : seq

    task automatic shout(output logic [23:0] v);
        u_prog_model.frame(4'h1, 24'h0, v);
    endtask : shout

    task automatic t_reset;
        `CHK(visibility_out, 16'h0000)
        `CHK(prog_data_oe_n, 1'b1)
    endtask : t_reset

    task automatic t_config;
        logic [23:0] v;
        logic [15:0] w;
        int          n;
        seq('{24'h000000, 24'h040200, 24'h000000, 24'h200f80, 24'h880190});
        `CHK(table_page, 8'hf8)
        // each word addressed on its own
        for (int k = 0; k < 16; k += 2)
        begin
            n = rd_cnt;
            seq('{24'h200006 | (24'(k) << 4), 24'h207847, 24'hba0bb6, 24'h0, 24'h0});
            `CHK(mem_addr, {8'hf8, 16'(k)})
            `CHK(rd_cnt, n + 1)
            shout(v);
            `CHK(v, {8'h00, memf({8'hf8, 16'(k)})})
            // shifted word's middle and lower bytes match the 16-bit memory word
            w = memf({8'hf8, 16'(k)});
            `CHK({v[15:8], v[7:0]}, {w[15:8], w[7:0]})
        end
        seq('{24'h040200, 24'h000000});
    endtask : t_config

    task automatic t_eeprom;
        logic [23:0] v;
        seq('{24'h2007f0, 24'h880190, 24'h2fe106, 24'h207847, 24'hba1b96, 24'h0, 24'h0});
        `CHK(table_page, 8'h7f)
        shout(v);
        `CHK(v, {8'h00, memf(24'h7ffe10)})
    endtask : t_eeprom

    task automatic t_appid;
        logic [23:0] v;
        int          n;
        n = rd_cnt;
        seq('{24'h200800, 24'h880190, 24'h205be0, 24'h207841, 24'hba0890, 24'h0, 24'h0});
        `CHK(rd_cnt, n)
        shout(v);
        `CHK(v, {8'h00, APP_ID})
    endtask : t_appid

    task automatic t_refuse;
        seq('{24'h208007, 24'hba0bb6, 24'h0, 24'h0});
        `CHK(visibility_out, APP_ID)
    endtask : t_refuse

    task automatic t_exit;
        // quiet interval before leaving the mode
        repeat (P16_CYC) @(posedge mclk);
        master_clear_pin <= 1'b0;
        repeat (8) @(posedge mclk);
        `CHK(visibility_out, 16'h0000)
        `CHK(table_page, 8'h00)
    endtask : t_exit

    task automatic end_of_test;
        if (mismatches == 0 && checked > 0)
            $display("Regression OK");
        else
            $display("Regression broken");
        $finish;
    endtask : end_of_test

    // Watchdog sized well above the roughly 43000 cycles of traffic
    initial
    begin
        repeat (90000) @(posedge mclk);
        mismatches++;
        end_of_test();
    end

    initial
    begin
        repeat (20) @(posedge mclk);
        rst_n <= 1'b1;
        master_clear_pin <= 1'b1;
        repeat (8) @(posedge mclk);
        t_reset();
        t_config();
        t_eeprom();
        t_appid();
        t_refuse();
        t_exit();
        end_of_test();
    end
endmodule : tb

/* File: src/pin_sync.sv */
// Two-flop synchroniser for one pin with edge detection on the synced level.
// Assumes the pin is asynchronous to clk and changes far slower than clk.
`timescale 1ns/1ps

module pin_sync (
    input  wire logic clk,
    input  wire logic rst_n,
    input  wire logic pin,
    output logic      level,
    output logic      rise,
    output logic      fall
);

    logic meta_r;
    logic sync_r;
    logic prev_r;

    // First flop is read only by the second; edges come from later stages
    always_ff @(posedge clk)
    begin
        if (!rst_n)
        begin
            meta_r <= 1'b0;
            sync_r <= 1'b0;
            prev_r <= 1'b0;
        end
        else
        begin
            meta_r <= pin;
            sync_r <= meta_r;
            prev_r <= sync_r;
        end
    end

    // Edge pulses last one clk cycle each
    assign level = sync_r;
    assign rise  = sync_r & ~prev_r;
    assign fall  = ~sync_r & prev_r;

endmodule : pin_sync

/* File: src/prog_port_pkg.sv */
// Constants shared by the serial programming port: frame layout, instruction
// encodings, memory pages and reset values.
// Assumes a single 125 MHz system clock domain for all users of the package.
package prog_port_pkg;

    // Frame layout: control code then payload, both shifted in LSB first
    localparam int         CODE_BITS      = 4;
    localparam int         PAYLOAD_BITS   = 24;
    localparam logic [4:0] FRAME_BITS     = 5'h1c;
    localparam logic [4:0] CODE_END       = 5'h04;
    localparam logic [4:0] UPPER_BYTE_POS = 5'h14;

    // Control codes
    localparam logic [3:0] SERIAL_EXECUTE_CODE     = 4'h0;
    localparam logic [3:0] REGISTER_SHIFT_OUT_CODE = 4'h1;

    // Instruction encodings that the port executes
    localparam logic [3:0]  MOV_LIT_OP     = 4'h2;
    localparam logic [23:0] MOV_W0_TABLE_PAGE_REGISTER  = 24'h880190;
    localparam logic [8:0]  TABLE_READ_OP  = 9'h174;
    localparam logic [2:0]  MODE_POST_INC  = 3'h3;

    // Register and memory map
    localparam logic [15:0] VISIBILITY_ADDR = 16'h0784;
    localparam logic [23:0] APP_ID_ADDR     = 24'h8005be;
    localparam logic [7:0]  CONFIG_PAGE     = 8'hf8;
    localparam logic [7:0]  EEPROM_PAGE     = 8'h7f;

    // Values after reset
    localparam logic [15:0] WREG_RESET      = 16'h0000;
    localparam logic [7:0]  TABLE_PAGE_REGISTER_RESET    = 8'h00;
    localparam logic [15:0] VISI_RESET      = 16'h0000;
    localparam logic [23:0] ADDR_RESET      = 24'h000000;

    // Table read sequencing
    typedef enum logic [1:0] {
        RD_IDLE,
        RD_REQ,
        RD_CAPTURE
    } rd_state_t;

endpackage : prog_port_pkg

/* File: src/serial_prog_config_readback.sv */
// Serial programming port: takes control code + payload frames on the
// programming clock/data pins, executes table reads into the visibility
// register and shifts that register back out.
// Assumes: memory answers mem_rdata the cycle after it samples mem_rd.
//
// Function
// - Configuration words read back as 16 bits; shifted upper byte is zero.
// - Table read places value in visibility register at 784h for shift out.
// - Application ID word sits at 8005BEh, readable by table read.
// - Application ID moves to visibility register, then shifts out.
// - Data EEPROM reads as 16-bit words with table page 0x7F.
`timescale 1ns/1ps

module serial_prog_config_readback
    import prog_port_pkg::*;
#(
    parameter logic [15:0] APP_ID_VALUE = 16'h005a  // Arbitrary neutral value
) (
    input  wire logic        mclk,
    input  wire logic        rst_n,
    input  wire logic        master_clear_pin,
    input  wire logic        prog_clock_pin,
    input  wire logic        prog_data_in,
    output logic             prog_data_out,
    output logic             prog_data_oe_n,
    output logic [23:0]      mem_addr,
    output logic             mem_rd,
    input  wire logic [15:0] mem_rdata,
    output logic [15:0]      visibility_out,
    output logic [7:0]       table_page
);
    import prog_port_pkg::*;

    // Post-increment of a word pointer by one word (two bytes)
    function automatic logic [15:0] inc2(input logic [15:0] v);
        inc2 = v + 16'h0002;
    endfunction : inc2

    logic        pgc_rise;
    logic        pgc_fall;
    logic        pgd_lvl;
    logic        mode_lvl;

    logic [4:0]  bit_cnt_r;
    logic [3:0]  code_r;
    logic [23:0] payload_r;
    logic [15:0] wreg_r [0:7];
    logic [7:0]  table_page_register_r;
    logic [15:0] visi_r;
    logic [23:0] out_sh_r;
    logic        dout_r;
    logic        oe_n_r;
    logic [23:0] mem_addr_r;
    logic        mem_rd_r;
    logic        app_hit_r;
    logic        dst_visi_r;
    rd_state_t   rd_st_r;

    // Pins are asynchronous to mclk: sync them all before use
    pin_sync u_pgc (
        .clk   (mclk),
        .rst_n (rst_n),
        .pin   (prog_clock_pin),
        .level (),
        .rise  (pgc_rise),
        .fall  (pgc_fall)
    );
    pin_sync u_pgd (
        .clk   (mclk),
        .rst_n (rst_n),
        .pin   (prog_data_in),
        .level (pgd_lvl),
        .rise  (),
        .fall  ()
    );
    pin_sync u_master_clear_pin (
        .clk   (mclk),
        .rst_n (rst_n),
        .pin   (master_clear_pin),
        .level (mode_lvl),
        .rise  (),
        .fall  ()
    );

    // Frame decode
    logic        eng_rst;
    logic        in_code;
    logic        in_register_shift_out_code;
    logic        frame_end;
    logic        exec_now;
    logic        is_movlit;
    logic        is_movtbl;
    logic        is_tblrd;
    logic [2:0]  src_idx;
    logic [2:0]  dst_idx;
    logic        src_inc;
    logic        dst_inc;
    logic [23:0] rd_addr;
    logic        rd_app;

    assign eng_rst   = !rst_n || !mode_lvl;
    assign in_code   = bit_cnt_r < CODE_END;
    assign in_register_shift_out_code = !in_code && code_r == REGISTER_SHIFT_OUT_CODE;
    assign frame_end = pgc_fall && bit_cnt_r == FRAME_BITS;
    assign exec_now  = frame_end && code_r == SERIAL_EXECUTE_CODE;
    assign is_movlit = payload_r[23:20] == MOV_LIT_OP && !payload_r[3];
    assign is_movtbl = payload_r == MOV_W0_TABLE_PAGE_REGISTER;
    assign is_tblrd  = payload_r[23:15] == TABLE_READ_OP && !payload_r[14];
    assign src_idx   = payload_r[2:0];
    assign dst_idx   = payload_r[9:7];
    assign src_inc   = payload_r[6:4] == MODE_POST_INC;
    assign dst_inc   = payload_r[13:11] == MODE_POST_INC;
    assign rd_addr   = {table_page_register_r, wreg_r[src_idx]};
    // ID word decoded at its executive address
    assign rd_app    = rd_addr == APP_ID_ADDR;

    // count 28 clocks per frame, capture code then payload
    always_ff @(posedge mclk)
    begin
        if (eng_rst)
        begin
            bit_cnt_r <= 5'h00;
            code_r    <= SERIAL_EXECUTE_CODE;
            payload_r <= ADDR_RESET;
        end
        else if (frame_end)
            bit_cnt_r <= 5'h00;
        else if (pgc_rise)
        begin
            bit_cnt_r <= bit_cnt_r + 5'h01;
            if (in_code)
                code_r <= {pgd_lvl, code_r[3:1]};
            else if (!in_register_shift_out_code)
                payload_r <= {pgd_lvl, payload_r[23:1]};
        end
    end

    // Shift-out drive: new bit on each rising clock, released at frame end;
    // host samples on falling edges so data is stable half a clock before
    // shift visibility register out
    always_ff @(posedge mclk)
    begin
        if (eng_rst || frame_end)
        begin
            dout_r   <= 1'b0;
            oe_n_r   <= 1'b1;
            out_sh_r <= ADDR_RESET;
        end
        else if (pgc_rise && in_register_shift_out_code)
        begin
            dout_r   <= out_sh_r[0];
            oe_n_r   <= 1'b0;
            out_sh_r <= {1'b0, out_sh_r[23:1]};
        end
        else if (pgc_rise && bit_cnt_r == CODE_END - 5'h01)
            // upper byte shifted out as zeros
            out_sh_r <= {8'h00, visi_r};
    end

    // Working registers and table page; one instruction per frame
    always_ff @(posedge mclk)
    begin
        if (eng_rst)
        begin
            for (int i = 0; i < 8; i++)
                wreg_r[i] <= WREG_RESET;
            table_page_register_r <= TABLE_PAGE_REGISTER_RESET;
        end
        else if (exec_now)
        begin
            for (int i = 0; i < 8; i++)
            begin
                if (is_movlit && payload_r[2:0] == i[2:0])
                    wreg_r[i] <= payload_r[19:4];
                else if (is_tblrd && src_inc && src_idx == i[2:0])
                    wreg_r[i] <= inc2(wreg_r[i]);
                else if (is_tblrd && dst_inc && dst_idx == i[2:0])
                    wreg_r[i] <= inc2(wreg_r[i]);
            end
            if (is_movtbl)
                table_page_register_r <= wreg_r[0][7:0];
        end
    end

    // Table read: request, wait one cycle, capture into visibility register.
    // Host NOPs after each read leave far more time than these three cycles.
    // table read into visibility register
    always_ff @(posedge mclk)
    begin
        if (eng_rst)
        begin
            rd_st_r    <= RD_IDLE;
            mem_addr_r <= ADDR_RESET;
            mem_rd_r   <= 1'b0;
            app_hit_r  <= 1'b0;
            dst_visi_r <= 1'b0;
            visi_r     <= VISI_RESET;
        end
        else
        begin
            mem_rd_r <= 1'b0;
            unique case (rd_st_r)
                RD_IDLE:
                    if (exec_now && is_tblrd)
                    begin
                        mem_addr_r <= rd_addr;
                        mem_rd_r   <= !rd_app;
                        app_hit_r  <= rd_app;
                        dst_visi_r <= wreg_r[dst_idx] == VISIBILITY_ADDR;
                        rd_st_r    <= RD_REQ;
                    end
                RD_REQ:
                    rd_st_r <= RD_CAPTURE;
                RD_CAPTURE:
                begin
                    // data and configuration words land as 16 bits
                    if (dst_visi_r)
                        visi_r <= app_hit_r ? APP_ID_VALUE : mem_rdata;
                    rd_st_r <= RD_IDLE;
                end
            endcase
        end
    end

    assign prog_data_out  = dout_r;
    assign prog_data_oe_n = oe_n_r;
    assign mem_addr       = mem_addr_r;
    assign mem_rd         = mem_rd_r;
    assign visibility_out = visi_r;
    assign table_page     = table_page_register_r;

    // Checks
    sequence s_tblrd_visi;
        exec_now && is_tblrd && wreg_r[dst_idx] == VISIBILITY_ADDR;
    endsequence

    AST_UPPER_ZERO: assert property (@(posedge mclk) disable iff (eng_rst)
        pgc_rise && in_register_shift_out_code && bit_cnt_r >= UPPER_BYTE_POS |=> !dout_r)
        else $error("upper byte of shifted word not zero");

    AST_VISI_LOAD: assert property (@(posedge mclk) disable iff (eng_rst)
        (s_tblrd_visi and !rd_app) |=> ##1 !mem_rd ##1 visi_r == $past(mem_rdata))
        else $error("table read did not load visibility register");

    AST_READ_ADDR: assert property (@(posedge mclk) disable iff (eng_rst)
        exec_now && is_tblrd |=> mem_addr_r == $past(rd_addr) && rd_st_r == RD_REQ)
        else $error("table read address wrong");

    AST_APP_ID: assert property (@(posedge mclk) disable iff (eng_rst)
        (s_tblrd_visi and rd_app) |=> !mem_rd ##2 visi_r == APP_ID_VALUE)
        else $error("application ID not placed in visibility register");

    AST_OE_ONLY_REGISTER_SHIFT_OUT_CODE: assert property (@(posedge mclk) disable iff (eng_rst)
        !oe_n_r |-> code_r == REGISTER_SHIFT_OUT_CODE && !in_code)
        else $error("data driven outside a shift-out frame");

    AST_EE_PAGE: assert property (@(posedge mclk) disable iff (eng_rst)
        exec_now && is_tblrd && table_page_register_r == EEPROM_PAGE |=> mem_addr_r[23:16] == EEPROM_PAGE)
        else $error("EEPROM page not used for table read");

    AST_FRAME_LEN: assert property (@(posedge mclk) disable iff (eng_rst)
        bit_cnt_r <= FRAME_BITS)
        else $error("frame bit count overran");

    AST_FRAME_END: assert property (@(posedge mclk) disable iff (eng_rst)
        frame_end |=> bit_cnt_r == 5'h00 && oe_n_r)
        else $error("frame end did not reset count and release data");

endmodule : serial_prog_config_readback
